//--- logic/epd_pkg.sv
// Package of constants for the encoder pulse divider.
package epd_pkg;
  // ----------------------------------------------------------------
  // Division ratio
  // ----------------------------------------------------------------
  localparam int EPD_RATIO_W = 15;
  localparam logic [14:0] EPD_RATIO_MIN = 15'h0001;
  localparam logic [14:0] EPD_RATIO_MAX = 15'h7fff;
  localparam logic [14:0] EPD_RATIO_RESET = 15'h0001;
  // ----------------------------------------------------------------
  // Quadrature step directions
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    EPD_DIR_NONE,
    EPD_DIR_FWD,
    EPD_DIR_REV
  } epd_dir_e;
endpackage

//--- logic/epd_phase_gen.sv
// Quadrature phase generator for one output step sequence.
`timescale 1ns/1ps
module epd_phase_gen (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic step_fwd_in,
  input wire logic step_rev_in,
  output logic a_out,
  output logic b_out
);
  import epd_pkg::*;
  logic [1:0] state_reg;
  logic [1:0] state_next;

  // Binary state 0..3 gives Gray-code A,B 00,10,11,01, A leading B when stepping forward.
  always_comb begin
    state_next = state_reg;
    if (step_fwd_in) begin
      state_next = state_reg + 2'h1; // R09
    end else if (step_rev_in) begin
      state_next = state_reg - 2'h1; // R09
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_reg <= 2'h0;
    end else begin
      state_reg <= state_next;
    end
  end

  // Counter 0..3 maps to A=0,1,1,0 and B=0,0,1,1: A leads by a quarter.
  always_comb begin
    a_out = state_reg[1] ^ state_reg[0]; // R07
    b_out = state_reg[1];
  end
endmodule

//--- logic/epd_divider.sv
// Top of the encoder pulse divider with its two output forms.
`timescale 1ns/1ps
// Functional notes
// R01: Divide A and B trains by integer n, 1 to 32767.
// R02: Z output follows Z input without division.
// R03: Divided high and low each last n input periods, 50% duty; the code holds each for 2n input steps, n/2 input periods.
// R04: Division ratio is 1 after reset, giving pass-through.
// R05: One ratio drives both open-collector and differential outputs.
// R06: All three phases appear on the output terminals.
// R07: A leading B by a quarter cycle means forward rotation.
// R08: A lagging B by 90 degrees means reverse rotation.
// R09: Divided A and B keep the quarter-cycle relation.
// R10: Each differential output has an always-inverse partner.
module epd_divider #(
  parameter logic [14:0] RATIO_RESET = epd_pkg::EPD_RATIO_RESET
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic enc_a_in,
  input wire logic enc_b_in,
  input wire logic enc_z_in,
  input wire logic [epd_pkg::EPD_RATIO_W-1:0] pulse_division_ratio_in,
  input wire logic ratio_load_in,
  output logic [epd_pkg::EPD_RATIO_W-1:0] pulse_division_ratio_out,
  output logic oc_a_phase_out,
  output logic oc_b_phase_out,
  output logic oc_z_phase_out,
  output logic diff_a_phase_out,
  output logic diff_a_phase_out_n,
  output logic diff_b_phase_out,
  output logic diff_b_phase_out_n,
  output logic diff_z_phase_out,
  output logic diff_z_phase_out_n
);
  import epd_pkg::*;

  // ----------------------------------------------------------------
  // Ratio setting
  // ----------------------------------------------------------------
  logic [14:0] ratio_reg;
  logic [14:0] ratio_next;
  logic a_prev_reg;
  logic b_prev_reg;
  logic a_prev_next;
  logic b_prev_next;
  logic [14:0] count_reg;
  logic [14:0] count_next;
  epd_dir_e dir;
  logic step_fwd;
  logic step_rev;
  logic a_div;
  logic b_div;
  logic z_reg;
  logic z_next;

  // Out-of-range values are ignored so the divider never sees zero.
  always_comb begin
    ratio_next = ratio_reg;
    if (ratio_load_in && pulse_division_ratio_in >= EPD_RATIO_MIN) begin
      ratio_next = pulse_division_ratio_in; // R01
    end
  end

  // ----------------------------------------------------------------
  // Input edge decode
  // ----------------------------------------------------------------
  // An edge on one input while the other holds is one quadrature step; its sense gives direction.
  always_comb begin
    a_prev_next = enc_a_in;
    b_prev_next = enc_b_in;
    dir = EPD_DIR_NONE;
    if (enc_a_in != a_prev_reg && enc_b_in == b_prev_reg) begin
      // A moved: forward when A now differs from B (A leads).
      dir = (enc_a_in != enc_b_in) ? EPD_DIR_FWD : EPD_DIR_REV; // R07
    end else if (enc_b_in != b_prev_reg && enc_a_in == a_prev_reg) begin
      // B moved: forward when B now equals A (B trails A).
      dir = (enc_a_in == enc_b_in) ? EPD_DIR_FWD : EPD_DIR_REV; // R08
    end
  end

  // ----------------------------------------------------------------
  // Step accumulator
  // ----------------------------------------------------------------
  // A signed-style window of n steps; one output step per n input
  // steps, so each output level spans n input half-periods. A direction
  // reversal unwinds the count instead of emitting a false step.
  always_comb begin
    count_next = count_reg;
    step_fwd = 1'b0;
    step_rev = 1'b0;
    if (dir == EPD_DIR_FWD) begin
      if (count_reg + 15'h0001 >= ratio_reg) begin
        count_next = 15'h0000;
        step_fwd = 1'b1; // R03
      end else begin
        count_next = count_reg + 15'h0001;
      end
    end else if (dir == EPD_DIR_REV) begin
      if (count_reg == 15'h0000) begin
        count_next = ratio_reg - 15'h0001;
        step_rev = 1'b1; // R03
      end else begin
        count_next = count_reg - 15'h0001;
      end
    end
    // Compare against the incoming ratio: a load that shrinks n would
    // otherwise leave the count at or above the new n for one cycle.
    if (count_next >= ratio_next) begin
      count_next = 15'h0000; // Ratio shrank under a running count.
    end
  end

  // Z takes the same one-cycle delay as the divided pair, keeping the
  // mark aligned with the A and B edges that a receiver sees.
  always_comb begin
    z_next = enc_z_in; // R02
  end

  // Divider state except the phase counter in u_phase; reset returns the ratio to pass-through.
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      ratio_reg <= RATIO_RESET; // R04
      a_prev_reg <= 1'b0;
      b_prev_reg <= 1'b0;
      count_reg <= 15'h0000;
      z_reg <= 1'b0;
    end else begin
      ratio_reg <= ratio_next;
      a_prev_reg <= a_prev_next;
      b_prev_reg <= b_prev_next;
      count_reg <= count_next;
      z_reg <= z_next;
    end
  end

  // ----------------------------------------------------------------
  // Output phase generation
  // ----------------------------------------------------------------
  epd_phase_gen u_phase (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .step_fwd_in(step_fwd),
    .step_rev_in(step_rev),
    .a_out(a_div),
    .b_out(b_div)
  );

  // Both output forms share one divided pair, so they cannot disagree.
  always_comb begin
    pulse_division_ratio_out = ratio_reg;
    oc_a_phase_out = a_div; // R05
    oc_b_phase_out = b_div; // R05
    oc_z_phase_out = z_reg; // R06
    diff_a_phase_out = a_div; // R05
    diff_b_phase_out = b_div; // R06
    diff_z_phase_out = z_reg; // R02
    diff_a_phase_out_n = ~a_div; // R10
    diff_b_phase_out_n = ~b_div; // R10
    diff_z_phase_out_n = ~z_reg; // R10
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  // Properties watch the pin outputs and internal state such as ratio_reg
  // and count_reg; the step strobes are triggers, and a_pass_through checks step_fwd.
  a_ratio_in_range: assert property (@(posedge clk_in) disable iff (rst_in)
    ratio_reg >= EPD_RATIO_MIN) // R01
    else $error("Division ratio fell below one.");
  a_ratio_loads: assert property (@(posedge clk_in) disable iff (rst_in)
    ratio_load_in && pulse_division_ratio_in != 15'h0000
    |=> ratio_reg == $past(pulse_division_ratio_in)) // R04
    else $error("Ratio load not taken.");
  a_z_follows: assert property (@(posedge clk_in) disable iff (rst_in)
    ##1 oc_z_phase_out == $past(enc_z_in)) // R02
    else $error("Z output does not follow Z input.");
  a_diff_inverse: assert property (@(posedge clk_in) disable iff (rst_in)
    diff_a_phase_out_n != diff_a_phase_out
    && diff_b_phase_out_n != diff_b_phase_out
    && diff_z_phase_out_n != diff_z_phase_out) // R10
    else $error("Differential pair not complementary.");
  a_forms_match: assert property (@(posedge clk_in) disable iff (rst_in)
    oc_a_phase_out == diff_a_phase_out
    && oc_b_phase_out == diff_b_phase_out) // R05
    else $error("Output forms disagree.");
  a_one_phase_moves: assert property (@(posedge clk_in) disable iff (rst_in)
    !(oc_a_phase_out != $past(oc_a_phase_out)
      && oc_b_phase_out != $past(oc_b_phase_out))) // R09
    else $error("Divided A and B changed together.");
  a_count_bound: assert property (@(posedge clk_in) disable iff (rst_in)
    count_reg < ratio_reg) // R03
    else $error("Step count reached the ratio.");
  a_pass_through: assert property (@(posedge clk_in) disable iff (rst_in)
    ratio_reg == 15'h0001 && dir == EPD_DIR_FWD |-> step_fwd) // R04
    else $error("Ratio one did not pass a step.");
  a_fwd_lead: assert property (@(posedge clk_in) disable iff (rst_in)
    step_fwd && !oc_a_phase_out && !oc_b_phase_out
    |=> oc_a_phase_out && !oc_b_phase_out) // R07
    else $error("Forward step did not move A first.");
  a_rev_lead: assert property (@(posedge clk_in) disable iff (rst_in)
    step_rev && !oc_a_phase_out && !oc_b_phase_out
    |=> !oc_a_phase_out && oc_b_phase_out) // R08
    else $error("Reverse step did not move B first.");
  a_ratio_zero: assert property (@(posedge clk_in) disable iff (rst_in)
    ratio_load_in && pulse_division_ratio_in == 15'h0000
    |=> $stable(ratio_reg)) // R01
    else $error("Zero ratio was taken.");
  a_ratio_holds: assert property (@(posedge clk_in) disable iff (rst_in)
    !ratio_load_in |=> $stable(ratio_reg)) // R04
    else $error("Ratio changed without a load.");
  a_fwd_second: assert property (@(posedge clk_in) disable iff (rst_in)
    step_fwd && oc_a_phase_out && !oc_b_phase_out
    |=> oc_a_phase_out && oc_b_phase_out) // R09
    else $error("Forward step did not move B after A.");

  c_fwd_step: cover property (@(posedge clk_in) disable iff (rst_in)
    step_fwd && ratio_reg > 15'h0001);
  c_rev_step: cover property (@(posedge clk_in) disable iff (rst_in)
    step_rev);
  c_ratio_change: cover property (@(posedge clk_in) disable iff (rst_in)
    ratio_load_in && pulse_division_ratio_in > 15'h0001);
  c_z_pulse: cover property (@(posedge clk_in) disable iff (rst_in)
    $rose(oc_z_phase_out));
  c_rev_wide: cover property (@(posedge clk_in) disable iff (rst_in)
    step_rev && ratio_reg > 15'h0001);
endmodule

//--- verification/epd_rx_model.sv
// Receiver model that counts quadrature steps of the divided outputs.
`timescale 1ns/1ps
module epd_rx_model (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic a_in,
  input wire logic b_in,
  output logic signed [15:0] pos_out
);
  logic a_reg;
  logic b_reg;
  // One phase moving alone is a step; both at once is noise and ignored.
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      a_reg <= 1'b0;
      b_reg <= 1'b0;
      pos_out <= 16'sh0000;
    end else begin
      a_reg <= a_in;
      b_reg <= b_in;
      if ((a_in != a_reg) && (b_in == b_reg)) begin
        pos_out <= (a_in != b_in) ? pos_out + 1'b1 : pos_out - 1'b1;
      end else if ((b_in != b_reg) && (a_in == a_reg)) begin
        pos_out <= (a_in == b_in) ? pos_out + 1'b1 : pos_out - 1'b1;
      end
    end
  end
endmodule

//--- verification/test_epd_divider.sv
// Self-checking testbench for the encoder pulse divider.
`timescale 1ns/1ps
module test_epd_divider;
  import epd_pkg::*;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic enc_a = 1'b0;
  logic enc_b = 1'b0;
  logic enc_z = 1'b0;
  logic ld = 1'b0;
  logic [14:0] ratio = 15'h0001;
  logic [14:0] ratio_q;
  logic oa, ob, oz, da, dan, db, dbn, dz, dzn, oa_q;
  logic signed [15:0] pos;
  logic [1:0] ph = 2'h0;
  logic [15:0] run = 16'h0000;
  logic [15:0] hi_len = 16'h0000;
  logic [15:0] lo_len = 16'h0000;
  int n_fail = 0;
  int check_count = 0;
  int cyc = 0;

  epd_divider dut (.clk_in(clk_in), .rst_in(rst_in), .enc_a_in(enc_a),
    .enc_b_in(enc_b), .enc_z_in(enc_z), .pulse_division_ratio_in(ratio),
    .ratio_load_in(ld), .pulse_division_ratio_out(ratio_q),
    .oc_a_phase_out(oa), .oc_b_phase_out(ob), .oc_z_phase_out(oz),
    .diff_a_phase_out(da), .diff_a_phase_out_n(dan),
    .diff_b_phase_out(db), .diff_b_phase_out_n(dbn),
    .diff_z_phase_out(dz), .diff_z_phase_out_n(dzn));
  epd_rx_model rx (.clk_in(clk_in), .rst_in(rst_in), .a_in(oa),
    .b_in(ob), .pos_out(pos));

  // Clock, plus a hang guard far above the few hundred cycles needed.
  initial forever #5 clk_in = ~clk_in;
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 3000) begin
      n_fail++;
      test_done();
    end
  end
  // Width of the last complete high and low level of divided A.
  always @(posedge clk_in) begin
    run <= (oa != oa_q) ? 16'h0001 : run + 16'h0001;
    oa_q <= oa;
    if (oa != oa_q && oa_q) hi_len <= run;
    if (oa != oa_q && !oa_q) lo_len <= run;
  end

  function automatic logic [1:0] ab(input logic [1:0] p);
    return {p[1] ^ p[0], p[1]};
  endfunction
  task automatic chk(input string nm, input logic [15:0] exp, got);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic outs(input logic [1:0] e, input logic z);
    chk("outs", {7'h00, e, z, e, z, ~e, ~z},
      {7'h00, oa, ob, oz, da, db, dz, dan, dbn, dzn});
  endtask
  // One input step every four cycles, so output latency has settled.
  task automatic step(input logic fwd, input int k);
    repeat (k) begin
      ph = fwd ? ph + 2'h1 : ph - 2'h1;
      @(posedge clk_in);
      {enc_a, enc_b} <= ab(ph);
      repeat (3) @(posedge clk_in);
      #1;
    end
  endtask
  task automatic load(input logic [14:0] n);
    @(posedge clk_in);
    ratio <= n;
    ld <= 1'b1;
    @(posedge clk_in);
    ld <= 1'b0;
    @(posedge clk_in);
    #1;
  endtask

  task automatic t_reset;
    chk("ratio", {1'b0, EPD_RATIO_RESET}, {1'b0, ratio_q});
    outs(2'h0, 1'b0);
  endtask
  task automatic t_pass;
    repeat (8) begin
      step(1'b1, 1);
      outs(ab(ph), 1'b0);
    end
    step(1'b0, 4);
    outs(ab(ph), 1'b0);
    chk("pos", 16'h0004, pos);
  endtask
  task automatic t_ratio;
    logic [1:0] p0;
    p0 = ph;
    load(15'h7fff);
    chk("ratio", 16'h7fff, {1'b0, ratio_q});
    load(15'h0003);
    load(15'h0000);
    chk("ratio", 16'h0003, {1'b0, ratio_q});
    step(1'b1, 12);
    step(1'b0, 6);
    outs(ab(p0 + 2'h2), 1'b0);
    chk("pos", 16'h0006, pos);
  endtask
  task automatic t_duty;
    load(15'h0002);
    step(1'b1, 16);
    chk("high", 16'h0010, hi_len);
    chk("low", 16'h0010, lo_len);
    chk("pos", 16'h000e, pos);
  endtask
  task automatic t_z;
    @(posedge clk_in);
    enc_z <= 1'b1;
    @(posedge clk_in);
    enc_z <= 1'b0;
    #1;
    chk("z", 16'h0006, {13'h0000, oz, dz, dzn});
    @(posedge clk_in);
    #1;
    chk("z", 16'h0001, {13'h0000, oz, dz, dzn});
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Reset for twelve cycles, then the scenarios in turn.
  initial begin
    repeat (12) @(posedge clk_in);
    rst_in <= 1'b0;
    @(posedge clk_in);
    #1;
    t_reset();
    t_pass();
    t_ratio();
    t_duty();
    t_z();
    test_done();
  end
endmodule
